//--- dtrc_adc_model.sv
// Purpose: Sample stream source standing in for the converters
// Assumes: Channel 0 carries a running sample index, others sit at mid scale except the wave lane
// Notes: Wave lane 0 means the external input carries the wave
`timescale 1ns/1ns
module dtrc_adc_model (
  input wire i_clk,
  input wire i_rstn,
  input wire i_slow,
  input wire [7:0] i_wave,
  input wire [3:0] i_wave_ch,
  output reg o_sample_valid,
  output reg [127:0] o_chan_samples,
  output reg [7:0] o_ext_sample
);
  reg [7:0] cnt_reg;
  reg ph_reg;
  integer k;
  // One sample set per cycle, or every other one when slow
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= 8'h00;
      ph_reg <= 1'b0;
      o_sample_valid <= 1'b0;
      o_chan_samples <= {16{8'h80}};
      o_ext_sample <= 8'h80;
    end else begin
      ph_reg <= ~ph_reg;
      o_sample_valid <= !i_slow || ph_reg;
      if (!i_slow || ph_reg) begin
        cnt_reg <= cnt_reg + 8'h01;
        for (k = 1; k < 16; k = k + 1)
          o_chan_samples[8*k +: 8] <= (k == i_wave_ch) ? i_wave : 8'h80;
        o_chan_samples[7:0] <= cnt_reg;
        o_ext_sample <= (i_wave_ch == 4'h0) ? i_wave : 8'h80;
      end else begin
        // Scrambled so idle lanes never look like a held sample
        o_chan_samples <= ~o_chan_samples;
        o_ext_sample <= ~o_ext_sample;
      end
    end
  end
endmodule

//--- dtrc_engine.v
// Purpose: One trigger engine: source select, slope and level compare
// Assumes: Samples are unsigned codes, 128 at mid scale
// Notes: Event is a one-cycle pulse on the cycle after the crossing sample
`timescale 1ns/1ns
`include "dtrc_regs.vh"

module dtrc_engine #(
  parameter NCH = 16
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_valid,
  input wire [NCH*8-1:0] i_chan,
  input wire [7:0] i_ext,
  input wire [4:0] i_source,
  input wire [1:0] i_slope,
  input wire [7:0] i_level,
  output reg o_event
);

  reg [7:0] prev_reg;
  reg have_reg;
  reg [7:0] cur;
  reg en;
  integer idx;

  // ==========================================================
  // Source decode; codes past the fitted channels act as disabled
  always @* begin
    cur = 8'h00;
    en = 1'b1;
    idx = 0;
    if (i_source == `DTRC_SRC_EXTERNAL_INPUT) begin
      cur = i_ext;
    end else if (i_source == `DTRC_SRC_DISABLED) begin
      en = 1'b0;
    end else begin
      if (i_source < `DTRC_SRC_CHANNEL_THIRD) begin
        idx = {27'h0000000, i_source};
      end else begin
        idx = {27'h0000000, i_source} - 32'h00000002;
      end
      if (idx < NCH) begin
        cur = i_chan[idx*8 +: 8];
      end else begin
        en = 1'b0;
      end
    end
  end

  // Unsigned compare, level code on the same scale as samples
  wire rise = (i_slope == `DTRC_SLOPE_RISING) && (prev_reg <= i_level) && (cur > i_level);
  wire fall = (i_slope == `DTRC_SLOPE_FALLING) && (prev_reg >= i_level) && (cur < i_level);

  // ==========================================================
  // Crossing detect; have_reg stops a false edge after re-enable
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_reg <= 8'h00;
      have_reg <= 1'b0;
      o_event <= 1'b0;
    end else begin
      o_event <= 1'b0;
      if (i_valid) begin
        prev_reg <= cur;
        have_reg <= en;
        o_event <= en && have_reg && (rise || fall);
      end
    end
  end

endmodule

//--- dtrc_history.v
// Purpose: Ring buffer giving the sample stream delayed by a set lag
// Assumes: Lag below the buffer depth
// Notes: Output registered, one cycle after each valid input
`timescale 1ns/1ns

module dtrc_history #(
  parameter W = 128,
  parameter AW = 10
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_valid,
  input wire [W-1:0] i_data,
  input wire [AW-1:0] i_lag,
  output reg o_valid,
  output reg [W-1:0] o_data
);

  reg [W-1:0] mem [0:(1<<AW)-1];
  reg [AW-1:0] wptr_reg;
  wire [AW-1:0] raddr = wptr_reg - i_lag;

  // ==========================================================
  // Storage has no reset; slots not yet written are read as unknown until the pointer has passed the lag
  always @(posedge i_clk) begin
    if (i_valid) begin
      mem[wptr_reg] <= i_data;
    end
  end

  // Read before write, so lag zero bypasses the memory
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wptr_reg <= {AW{1'b0}};
      o_valid <= 1'b0;
      o_data <= {W{1'b0}};
    end else begin
      o_valid <= i_valid;
      if (i_valid) begin
        wptr_reg <= wptr_reg + 1'b1;
        o_data <= (i_lag == {AW{1'b0}}) ? i_data : mem[raddr];
      end
    end
  end

endmodule

//--- dtrc_regs.vh
// Purpose: Offsets, fields, codes, reset values and limits of the trigger/record block
// Assumes: Included by the dtrc engine and top design files
// Notes: Offsets are byte addresses of aligned 32-bit words
`ifndef DTRC_REGS_VH
`define DTRC_REGS_VH

// ==========================================================
// Register byte offsets
`define DTRC_OFS_CTRL 6'h00
`define DTRC_OFS_OP 6'h04
`define DTRC_OFS_ENG 6'h08
`define DTRC_OFS_EXT 6'h0c
`define DTRC_OFS_DELAY 6'h10
`define DTRC_OFS_PRE 6'h14
`define DTRC_OFS_POST 6'h18
`define DTRC_OFS_RCNT 6'h1c
`define DTRC_OFS_RDONE 6'h20

// ==========================================================
// Field positions
`define DTRC_CTRL_ARM 0
`define DTRC_CTRL_ABORT 1
`define DTRC_STAT_BUSY 0
`define DTRC_STAT_TRIG 1
`define DTRC_STAT_DONE 2
`define DTRC_STAT_OPBAD 3
`define DTRC_ENG_SRC_LSB 0
`define DTRC_ENG_SLOPE_LSB 8
`define DTRC_ENG_LVL_LSB 16
`define DTRC_ENG_ID 24

// ==========================================================
// Combine operations, sources, slopes, ranges
`define DTRC_OP_FIRST_ONLY 3'h0
`define DTRC_OP_SECOND_ONLY 3'h1
`define DTRC_OP_EITHER_ENGINE 3'h2
`define DTRC_SRC_CHANNEL_FIRST 5'h00
`define DTRC_SRC_EXTERNAL_INPUT 5'h02
`define DTRC_SRC_DISABLED 5'h03
`define DTRC_SRC_CHANNEL_THIRD 5'h04
`define DTRC_SRC_CHANNEL_LAST 5'h11
`define DTRC_SLOPE_RISING 2'h1
`define DTRC_SLOPE_FALLING 2'h2
`define DTRC_EXT_RANGE_MAX 3'h4

// ==========================================================
// Reset values and limits
`define DTRC_RST_OP 3'h0
`define DTRC_RST_SRC 5'h00
`define DTRC_RST_SLOPE 2'h1
`define DTRC_RST_LVL 8'h80
`define DTRC_RST_EXT 3'h0
`define DTRC_RST_DELAY 24'h000000
`define DTRC_RST_PRE 16'h0000
`define DTRC_RST_POST 16'h0040
`define DTRC_RST_RCNT 18'h00001
`define DTRC_DELAY_MAX 24'h98967f

`endif

//--- dtrc_top.v
// Purpose: Two trigger engines, combine, post-trigger delay and record framing
// Assumes: Sample stream synchronous to i_clk; Avalon-MM slave, byte address
// Notes: Records leave as a stream of all channels, pre-trigger part first
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
`include "dtrc_regs.vh"

module dtrc_top #(
  parameter NCH = 16,
  parameter HIST_AW = 10,
  parameter DELAY_GRAN = 1,
  parameter SINGLE_EXT_LEVEL = 1
) (
  input wire i_clk,
  input wire i_rstn,
  input wire [5:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  input wire i_sample_valid,
  input wire [NCH*8-1:0] i_chan_samples,
  input wire [7:0] i_ext_sample,
  output reg [2:0] o_ext_range,
  output reg o_board_trigger,
  output reg o_triggered,
  output reg o_rec_valid,
  output reg [NCH*8-1:0] o_rec_data,
  output reg o_rec_first,
  output reg o_rec_last
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ARMED = 3'h1;
  localparam [2:0] ST_DELAY = 3'h2;
  localparam [2:0] ST_CAPTURE = 3'h3;
  localparam [2:0] ST_DONE = 3'h4;
  localparam [23:0] GRAN24 = DELAY_GRAN[23:0];

  // ==========================================================
  // Configuration and state
  reg [2:0] op_reg;
  reg [4:0] src1_reg;
  reg [4:0] src2_reg;
  reg [1:0] slope1_reg;
  reg [1:0] slope2_reg;
  reg [7:0] lvl1_reg;
  reg [7:0] lvl2_reg;
  reg sel_reg;
  reg [23:0] delay_reg;
  reg [15:0] pre_reg;
  reg [15:0] post_reg;
  reg [17:0] rcnt_reg;
  reg [17:0] rdone_reg;
  reg [2:0] state_reg;
  reg [23:0] dcnt_reg;
  reg [16:0] scnt_reg;
  reg [31:0] rd_word;
  reg [31:0] wr_word;
  reg trig_comb;
  integer i;

  wire ev1;
  wire ev2;
  wire hist_valid;
  wire [NCH*8-1:0] hist_data;

  // ==========================================================
  // Bus strobes: a request is answered on its second cycle
  wire wr_fire = i_avs_write && !o_avs_waitrequest;
  wire rd_take = i_avs_read && o_avs_waitrequest;
  wire [3:0] be = i_avs_byteenable;
  wire ctrl_wr = wr_fire && (i_avs_address == `DTRC_OFS_CTRL) && be[0];
  wire arm_now = ctrl_wr && i_avs_writedata[`DTRC_CTRL_ARM];
  wire abort_now = ctrl_wr && i_avs_writedata[`DTRC_CTRL_ABORT];

  // Single shared external comparator level on such variants
  wire both_ext = (src1_reg == `DTRC_SRC_EXTERNAL_INPUT) && (src2_reg == `DTRC_SRC_EXTERNAL_INPUT);
  wire [7:0] lvl1_use = (SINGLE_EXT_LEVEL != 0 && both_ext) ? lvl2_reg : lvl1_reg;

  // Delay rounded down to the variant's step
  wire [23:0] delay_eff = delay_reg - (delay_reg % GRAN24);

  wire busy = (state_reg == ST_ARMED) || (state_reg == ST_DELAY) || (state_reg == ST_CAPTURE);
  wire op_bad = (op_reg > `DTRC_OP_EITHER_ENGINE);
  wire [16:0] rec_len = {1'b0, pre_reg} + {1'b0, post_reg};
  wire [23:0] dcnt_inc = dcnt_reg + 24'h000001;
  wire [16:0] scnt_inc = scnt_reg + 17'h00001;
  wire [17:0] rdone_inc = rdone_reg + 18'h00001;

  // ==========================================================
  // Engines and pre-trigger history
  dtrc_engine #(.NCH(NCH)) u_eng1 (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_valid(i_sample_valid),
    .i_chan(i_chan_samples),
    .i_ext(i_ext_sample),
    .i_source(src1_reg),
    .i_slope(slope1_reg),
    .i_level(lvl1_use),
    .o_event(ev1)
  );

  dtrc_engine #(.NCH(NCH)) u_eng2 (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_valid(i_sample_valid),
    .i_chan(i_chan_samples),
    .i_ext(i_ext_sample),
    .i_source(src2_reg),
    .i_slope(slope2_reg),
    .i_level(lvl2_reg),
    .o_event(ev2)
  );

  // Lag is the low HIST_AW bits of the pre count, so history output starts the record while pre is below the depth
  dtrc_history #(.W(NCH*8), .AW(HIST_AW)) u_hist (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_valid(i_sample_valid),
    .i_data(i_chan_samples),
    .i_lag(pre_reg[HIST_AW-1:0]),
    .o_valid(hist_valid),
    .o_data(hist_data)
  );

  // ==========================================================
  // Combine the two engines; retired codes give no trigger
  always @* begin
    case (op_reg)
      `DTRC_OP_FIRST_ONLY: trig_comb = ev1;
      `DTRC_OP_SECOND_ONLY: trig_comb = ev2;
      `DTRC_OP_EITHER_ENGINE: trig_comb = ev1 | ev2;
      default: trig_comb = 1'b0;
    endcase
  end

  // Only an armed, idle-between-records state listens to triggers
  wire board_hit = (state_reg == ST_ARMED) && trig_comb;
  wire start_cap = (board_hit && delay_eff == 24'h000000) ||
                   (state_reg == ST_DELAY && hist_valid && dcnt_inc == delay_eff);
  wire take = hist_valid && ((state_reg == ST_CAPTURE) || start_cap);
  wire last = (scnt_inc >= rec_len);

  // ==========================================================
  // Read mux, also the base word for byte-lane merging
  always @* begin
    rd_word = 32'h00000000;
    case (i_avs_address)
      `DTRC_OFS_CTRL: begin
        rd_word[`DTRC_STAT_BUSY] = busy;
        rd_word[`DTRC_STAT_TRIG] = o_triggered;
        rd_word[`DTRC_STAT_DONE] = (state_reg == ST_DONE);
        rd_word[`DTRC_STAT_OPBAD] = op_bad;
      end
      `DTRC_OFS_OP: rd_word[2:0] = op_reg;
      `DTRC_OFS_ENG: begin
        rd_word[`DTRC_ENG_SRC_LSB +: 5] = sel_reg ? src2_reg : src1_reg;
        rd_word[`DTRC_ENG_SLOPE_LSB +: 2] = sel_reg ? slope2_reg : slope1_reg;
        rd_word[`DTRC_ENG_LVL_LSB +: 8] = sel_reg ? lvl2_reg : lvl1_reg;
        rd_word[`DTRC_ENG_ID] = sel_reg;
      end
      `DTRC_OFS_EXT: rd_word[2:0] = o_ext_range;
      `DTRC_OFS_DELAY: rd_word[23:0] = delay_reg;
      `DTRC_OFS_PRE: rd_word[15:0] = pre_reg;
      `DTRC_OFS_POST: rd_word[15:0] = post_reg;
      `DTRC_OFS_RCNT: rd_word[17:0] = rcnt_reg;
      `DTRC_OFS_RDONE: rd_word[17:0] = rdone_reg;
      default: rd_word = 32'h00000000;
    endcase
  end

  // Byte enables pick write data lanes over the current value
  always @* begin
    wr_word = rd_word;
    for (i = 0; i < 4; i = i + 1) begin
      if (be[i]) begin
        wr_word[i*8 +: 8] = i_avs_writedata[i*8 +: 8];
      end
    end
  end

  // ==========================================================
  // Avalon handshake: waitrequest drops for one cycle per request
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
    end else begin
      if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
        o_avs_waitrequest <= 1'b0;
      end else begin
        o_avs_waitrequest <= 1'b1;
      end
      if (rd_take) begin
        o_avs_readdata <= rd_word;
      end
    end
  end

  // ==========================================================
  // Configuration writes; changes apply at once, even mid-acquisition
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      op_reg <= `DTRC_RST_OP;
      src1_reg <= `DTRC_RST_SRC;
      src2_reg <= `DTRC_RST_SRC;
      slope1_reg <= `DTRC_RST_SLOPE;
      slope2_reg <= `DTRC_RST_SLOPE;
      lvl1_reg <= `DTRC_RST_LVL;
      lvl2_reg <= `DTRC_RST_LVL;
      sel_reg <= 1'b0;
      o_ext_range <= `DTRC_RST_EXT;
      delay_reg <= `DTRC_RST_DELAY;
      pre_reg <= `DTRC_RST_PRE;
      post_reg <= `DTRC_RST_POST;
      rcnt_reg <= `DTRC_RST_RCNT;
    end else if (wr_fire) begin
      case (i_avs_address)
        `DTRC_OFS_OP: op_reg <= wr_word[2:0];
        `DTRC_OFS_ENG: begin
          sel_reg <= wr_word[`DTRC_ENG_ID];
          if (wr_word[`DTRC_ENG_ID]) begin
            src2_reg <= wr_word[`DTRC_ENG_SRC_LSB +: 5];
            slope2_reg <= wr_word[`DTRC_ENG_SLOPE_LSB +: 2];
            lvl2_reg <= wr_word[`DTRC_ENG_LVL_LSB +: 8];
          end else begin
            src1_reg <= wr_word[`DTRC_ENG_SRC_LSB +: 5];
            slope1_reg <= wr_word[`DTRC_ENG_SLOPE_LSB +: 2];
            lvl1_reg <= wr_word[`DTRC_ENG_LVL_LSB +: 8];
          end
        end
        `DTRC_OFS_EXT: begin
          // Codes above the top range are dropped, old range kept
          if (wr_word[31:3] == 29'h00000000 && wr_word[2:0] <= `DTRC_EXT_RANGE_MAX) begin
            o_ext_range <= wr_word[2:0];
          end
        end
        `DTRC_OFS_DELAY: begin
          if (wr_word[31:24] != 8'h00 || wr_word[23:0] > `DTRC_DELAY_MAX) begin
            delay_reg <= `DTRC_DELAY_MAX;
          end else begin
            delay_reg <= wr_word[23:0];
          end
        end
        `DTRC_OFS_PRE: pre_reg <= wr_word[15:0];
        `DTRC_OFS_POST: post_reg <= wr_word[15:0];
        `DTRC_OFS_RCNT: rcnt_reg <= wr_word[17:0];
        default: op_reg <= op_reg;
      endcase
    end
  end

  // ==========================================================
  // Acquisition sequencer: arm, wait trigger, delay, capture records
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ST_IDLE;
      dcnt_reg <= 24'h000000;
      scnt_reg <= 17'h00000;
      rdone_reg <= 18'h00000;
      o_triggered <= 1'b0;
      o_board_trigger <= 1'b0;
      o_rec_valid <= 1'b0;
      o_rec_data <= {NCH*8{1'b0}};
      o_rec_first <= 1'b0;
      o_rec_last <= 1'b0;
    end else begin
      o_board_trigger <= board_hit && !arm_now && !abort_now; // Pulse only when flag is set too
      o_rec_valid <= 1'b0;
      o_rec_first <= 1'b0;
      o_rec_last <= 1'b0;
      if (abort_now) begin
        state_reg <= ST_IDLE;
      end else if (arm_now) begin
        // Re-arm restarts the count and clears the sticky flag
        o_triggered <= 1'b0;
        rdone_reg <= 18'h00000;
        scnt_reg <= 17'h00000;
        state_reg <= (rcnt_reg == 18'h00000) ? ST_DONE : ST_ARMED;
      end else begin
        if (board_hit) begin
          o_triggered <= 1'b1;
        end
        case (state_reg)
          ST_IDLE: state_reg <= ST_IDLE;
          ST_DONE: state_reg <= ST_DONE;
          ST_ARMED: begin
            if (board_hit && !start_cap) begin
              dcnt_reg <= 24'h000000;
              state_reg <= ST_DELAY;
            end
          end
          ST_DELAY: begin
            if (hist_valid) begin
              dcnt_reg <= dcnt_inc;
            end
          end
          ST_CAPTURE: state_reg <= ST_CAPTURE;
          default: state_reg <= ST_IDLE;
        endcase
        if (take) begin
          o_rec_valid <= 1'b1;
          o_rec_data <= hist_data;
          o_rec_first <= (scnt_reg == 17'h00000);
          o_rec_last <= last;
          if (last) begin
            // Back to armed only once the record is complete
            scnt_reg <= 17'h00000;
            rdone_reg <= rdone_inc;
            state_reg <= (rdone_inc >= rcnt_reg) ? ST_DONE : ST_ARMED;
          end else begin
            scnt_reg <= scnt_inc;
            state_reg <= ST_CAPTURE;
          end
        end
      end
    end
  end

endmodule

//--- dtrc_trig_monitor.sv
// Purpose: Port-level checks of the trigger/record block
// Assumes: Single clock domain, async active-low reset
// Notes: Arming is a CTRL write with bit 0 set and bit 1 clear
`timescale 1ns/1ns
module dtrc_trig_monitor (
  input wire i_clk,
  input wire i_rstn,
  input wire [5:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire i_sample_valid,
  input wire [2:0] o_ext_range,
  input wire o_board_trigger,
  input wire o_triggered,
  input wire o_rec_valid,
  input wire o_rec_first,
  input wire o_rec_last
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ========
  // Steps of a record and of an arm
  sequence s_rec_open;
    o_rec_valid && o_rec_first && !o_rec_last;
  endsequence
  sequence s_rec_close;
    o_rec_valid && o_rec_last;
  endsequence
  sequence s_arm_write;
    i_avs_write && !o_avs_waitrequest && i_avs_address == 6'h00
      && i_avs_byteenable[0] && i_avs_writedata[0] && !i_avs_writedata[1];
  endsequence
  // ========
  // Register bus
  a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("bus request not answered in one wait");
  a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than a cycle");
  a_rdata_hold: assert property (!i_avs_read |=> $stable(o_avs_readdata))
    else $error("read data moved without a read");
  a_ext_legal: assert property (o_ext_range <= 3'h4)
    else $error("external range code out of range");
  // ========
  // Open-record tracker; a control write abandons the record
  logic in_rec_reg;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      in_rec_reg <= 1'b0;
    end else if (o_rec_valid && o_rec_last) begin
      in_rec_reg <= 1'b0;
    end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == 6'h00) begin
      in_rec_reg <= 1'b0;
    end else if (o_rec_valid && o_rec_first) begin
      in_rec_reg <= 1'b1;
    end
  end
  // Trigger acceptance, record bound and sticky flag
  a_trig_single: assert property (o_board_trigger |=> !o_board_trigger)
    else $error("board trigger longer than a pulse");
  a_trig_quiet: assert property (in_rec_reg |-> !o_board_trigger)
    else $error("trigger accepted during capture");
  a_rec_bounded: assert property (s_rec_open |-> ##[1:1000] s_rec_close)
    else $error("record never closed");
  a_sticky_set: assert property (o_board_trigger |-> o_triggered)
    else $error("sticky flag not set by trigger");
  a_sticky_hold: assert property (o_triggered && !i_avs_write |=> o_triggered)
    else $error("sticky flag dropped on its own");
  a_sticky_clear: assert property (s_arm_write |=> !o_triggered)
    else $error("sticky flag kept over arm");
  // ========
  // Record stream; output lags the input sample by two edges
  a_rec_flags: assert property (o_rec_first || o_rec_last |-> o_rec_valid)
    else $error("record flag without valid");
  a_rec_paced: assert property (o_rec_valid |-> $past(i_sample_valid, 2))
    else $error("record sample without input sample");
endmodule
bind dtrc_top dtrc_trig_monitor u_dtrc_trig_monitor (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_sample_valid(i_sample_valid), .o_ext_range(o_ext_range),
  .o_board_trigger(o_board_trigger), .o_triggered(o_triggered), .o_rec_valid(o_rec_valid),
  .o_rec_first(o_rec_first), .o_rec_last(o_rec_last));

//--- tb.sv
// Purpose: Self-checking bench of the trigger/record block
// Assumes: One wait cycle per bus access, default parameters
// Notes: Sample index rides on channel 0 to check record framing
`timescale 1ns/1ns
module tb;
  logic i_clk, i_rstn, rd_s, wr_s, slow, svalid, waitreq, brd_trig, trig_flag;
  logic rec_v, rec_f, rec_l;
  logic [5:0] adr;
  logic [31:0] wdat, rdat, d;
  logic [2:0] ext_rng;
  logic [127:0] chan, rec_d;
  logic [7:0] ext, wave, prev1, xidx, x0, rfirst, dfirst;
  logic [4:0] wc5;
  logic [3:0] wch;
  int num_errors, cmp_count, ntrig, nrec, rlen, dlen, k, ex;
  logic [5:0] ofs [10] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h20, 6'h24};
  logic [31:0] ev [10] = '{32'h0, 32'h0, 32'h800100, 32'h0, 32'h0, 32'h0, 32'h40, 32'h1,
    32'h0, 32'h0};
  logic [4:0] src [4] = '{5'h01, 5'h03, 5'h04, 5'h11};
  dtrc_top u_dtrc_top (.i_clk(i_clk), .i_rstn(i_rstn), .i_avs_address(adr),
    .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdat), .o_avs_waitrequest(waitreq), .i_sample_valid(svalid),
    .i_chan_samples(chan), .i_ext_sample(ext), .o_ext_range(ext_rng),
    .o_board_trigger(brd_trig), .o_triggered(trig_flag), .o_rec_valid(rec_v),
    .o_rec_data(rec_d), .o_rec_first(rec_f), .o_rec_last(rec_l));
  dtrc_adc_model u_dtrc_adc_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_slow(slow),
    .i_wave(wave), .i_wave_ch(wch), .o_sample_valid(svalid), .o_chan_samples(chan),
    .o_ext_sample(ext));
  // ========
  // Clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task stop_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Bus master: request held until waitrequest is seen low
  task wr(input [5:0] a, input [31:0] v);
    @(posedge i_clk);
    adr <= a;
    wdat <= v;
    wr_s <= 1'b1;
    @(posedge i_clk);
    while (waitreq !== 1'b0) @(posedge i_clk);
    wr_s <= 1'b0;
  endtask
  task rd(input [5:0] a);
    @(posedge i_clk);
    adr <= a;
    rd_s <= 1'b1;
    @(posedge i_clk);
    while (waitreq !== 1'b0) @(posedge i_clk);
    d = rdat;
    rd_s <= 1'b0;
  endtask
  task eng(input logic id, input [4:0] s, input [1:0] sl, input [7:0] lv);
    wr(6'h08, {7'h0, id, lv, 6'h0, sl, 3'h0, s});
  endtask
  // Short excursion of one lane, then a quiet gap
  task pulse(input [3:0] c, input [7:0] v, input int gap);
    @(posedge i_clk);
    wch <= c;
    wave <= v;
    repeat (6) @(posedge i_clk);
    wave <= 8'h80;
    repeat (gap) @(posedge i_clk);
  endtask
  // Tallies of triggers, crossings and finished records
  always @(posedge i_clk) begin
    if (brd_trig === 1'b1) ntrig++;
    if (svalid === 1'b1) begin
      if (chan[15:8] > 8'h90 && prev1 <= 8'h90) xidx = chan[7:0];
      prev1 = chan[15:8];
    end
    if (rec_v === 1'b1) begin
      if (rec_f === 1'b1) begin
        rfirst = rec_d[7:0];
        rlen = 0;
      end
      rlen++;
      if (rec_l === 1'b1) begin
        nrec++;
        dfirst = rfirst;
        dlen = rlen;
      end
    end
  end
  // Hang guard, well above the expected run of about 6800 cycles
  initial begin
    repeat (40000) @(posedge i_clk);
    num_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    stop_test;
  end
  // ========
  // Main sequence
  initial begin
    i_rstn = 1'b0;
    rd_s = 1'b0;
    wr_s = 1'b0;
    slow = 1'b0;
    adr = 6'h0;
    wdat = 32'h0;
    wave = 8'h80;
    wch = 4'h1;
    prev1 = 8'h80;
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (k = 0; k < 10; k++) begin
      rd(ofs[k]);
      chk(d, ev[k]);
    end
    wr(6'h20, 32'h5);
    rd(6'h20);
    chk(d, 32'h0);
    wr(6'h0c, 32'h4);
    rd(6'h0c);
    chk(d, 32'h4);
    chk({29'h0, ext_rng}, 32'h4);
    wr(6'h0c, 32'h5);
    rd(6'h0c);
    chk(d, 32'h4);
    wr(6'h10, 32'hffffff);
    rd(6'h10);
    chk(d, 32'h98967f);
    wr(6'h10, 32'h0);
    wr(6'h1c, 32'h2);
    eng(1'b0, 5'h01, 2'h1, 8'h90);
    eng(1'b1, 5'h01, 2'h2, 8'h70);
    for (k = 0; k < 7; k++) begin
      wr(6'h04, k);
      wr(6'h00, 32'h1);
      ntrig = 0;
      pulse(4'h1, 8'h90, 100);
      pulse(4'h1, 8'h70, 100);
      chk(ntrig, 0);
      ex = (k == 0 || k == 2);
      pulse(4'h1, 8'ha0, 200);
      chk(ntrig, ex);
      ex += (k == 1 || k == 2);
      pulse(4'h1, 8'h50, 200);
      chk(ntrig, ex);
      rd(6'h00);
      chk({31'h0, d[3]}, {31'h0, k > 2});
      wr(6'h00, 32'h2);
    end
    eng(1'b0, 5'h02, 2'h1, 8'h20);
    eng(1'b1, 5'h02, 2'h1, 8'hc0);
    rd(6'h08);
    chk(d, 32'h1c00102);
    wr(6'h04, 32'h0);
    wr(6'h00, 32'h1);
    ntrig = 0;
    pulse(4'h0, 8'h60, 200);
    chk(ntrig, 0);
    pulse(4'h0, 8'hd0, 200);
    chk(ntrig, 1);
    chk({31'h0, trig_flag}, 32'h1);
    wr(6'h00, 32'h1);
    @(posedge i_clk);
    chk({31'h0, trig_flag}, 32'h0);
    for (k = 0; k < 4; k++) begin
      eng(1'b0, src[k], 2'h1, 8'h90);
      wr(6'h00, 32'h1);
      ntrig = 0;
      wc5 = src[k] - 5'h2;
      pulse(src[k] < 5'h4 ? 4'h1 : wc5[3:0], 8'ha0, 200);
      chk(ntrig, src[k] != 5'h3);
    end
    wr(6'h00, 32'h2);
    slow <= 1'b1;
    wr(6'h14, 32'h3);
    wr(6'h10, 32'h5);
    eng(1'b0, 5'h01, 2'h1, 8'h90);
    wr(6'h00, 32'h1);
    ntrig = 0;
    nrec = 0;
    // Gap puts the second crossing inside the capture window
    pulse(4'h1, 8'ha0, 30);
    x0 = xidx;
    pulse(4'h1, 8'ha0, 300);
    chk(ntrig, 1);
    chk({24'h0, dfirst}, {24'h0, x0 + 8'h2});
    chk(dlen, 67);
    pulse(4'h1, 8'ha0, 300);
    pulse(4'h1, 8'ha0, 300);
    chk(ntrig, 2);
    chk(nrec, 2);
    rd(6'h20);
    chk(d, 32'h2);
    rd(6'h00);
    chk({29'h0, d[2:0]}, 32'h6);
    stop_test;
  end
endmodule
